// *** hw/hsq_pkg.sv ***
// Purpose: Shared constants and types for the homing sequencer.
// Assumes: One 200 MHz system clock, active-low asynchronous reset.
// Notes:   Method numbers are eight-bit unsigned; other values decode as unsupported.
package hsq_pkg;

  localparam int GEN_IN_W = 8;
  localparam int SEL_W    = 3;
  localparam int SYNC_W   = GEN_IN_W + 1;
  localparam int HOME_W   = 32;

  // Default switch assignment: general inputs one, two and three.
  localparam logic [SEL_W-1:0] NEG_LIMIT_SEL_RST = 3'h0;
  localparam logic [SEL_W-1:0] POS_LIMIT_SEL_RST = 3'h1;
  localparam logic [SEL_W-1:0] HOME_SEL_RST      = 3'h2;

  // Stored method after reset; zero is not an executable method.
  localparam logic [7:0] METHOD_RST = 8'h00;

  // Method groups: first number of each group and group spans.
  localparam logic [7:0] M_SINGLE_IDX_LO = 8'h03;
  localparam logic [7:0] M_REGION_IDX_LO = 8'h07;
  localparam logic [7:0] M_LIMIT_NEG     = 8'h11;
  localparam logic [7:0] M_LIMIT_POS     = 8'h12;
  localparam logic [7:0] M_SINGLE_LO     = 8'h13;
  localparam logic [7:0] M_REGION_LO     = 8'h17;
  localparam logic [7:0] M_INDEX_NEG     = 8'h21;
  localparam logic [7:0] M_INDEX_POS     = 8'h22;
  localparam logic [7:0] SINGLE_SPAN     = 8'h04;
  localparam logic [7:0] REGION_SPAN     = 8'h08;

  typedef enum logic [1:0] {
    SIG_NONE      = 2'h0,
    SIG_HOME      = 2'h1,
    SIG_NEG_LIMIT = 2'h2,
    SIG_POS_LIMIT = 2'h3
  } hsq_sig_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_SEEK  = 4'h2,
    ST_CROSS = 4'h4,
    ST_INDEX = 4'h8
  } hsq_state_t;

  typedef struct packed {
    logic     valid;
    hsq_sig_t sig;
    logic     region;
    logic     edge_upper;
    logic     start_pos;
    logic     pos_active;
    logic     use_index;
    logic     final_pos;
  } hsq_profile_t;

  typedef struct packed {
    logic [SEL_W-1:0] neg_sel;
    logic [SEL_W-1:0] pos_sel;
    logic [SEL_W-1:0] home_sel;
  } hsq_map_t;

  typedef struct packed {
    logic active;
    logic dir_pos;
    logic slow;
  } hsq_motion_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic error;
    logic unsupported;
  } hsq_status_t;

endpackage : hsq_pkg

// *** hw/hsq_sync.sv ***
// Purpose: Two-stage synchroniser with edge detection for axis pins.
// Assumes: Inputs are asynchronous to clk.
// Notes:   Edges are flagged in the same cycle as the synchronised level changes.
`timescale 1ns/1ps
module hsq_sync #(
  parameter int W = 9
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Pins
  input  wire logic [W-1:0] async_in,
  // Synchronised view
  output logic [W-1:0]      level,
  output logic [W-1:0]      rise,
  output logic [W-1:0]      fall
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] last_reg;

  // The first stage feeds only the second, so metastability never reaches logic.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~last_reg;
  assign fall  = ~sync_reg & last_reg;

endmodule : hsq_sync

// *** hw/hsq_method_dec.sv ***
// Purpose: Decode a homing method number into a search profile.
// Assumes: Method held stable while a run is in progress.
// Notes:   Unknown and reserved numbers yield a profile with valid low.
`timescale 1ns/1ps
module hsq_method_dec (
  // Selected method
  input  wire logic [7:0]   method,
  // Decoded profile
  output hsq_pkg::hsq_profile_t profile
);

  logic [7:0] k_si;
  logic [7:0] k_ri;
  logic [7:0] k_sw;
  logic [7:0] k_rw;

  function automatic logic in_span(input logic [7:0] m, input logic [7:0] base,
                                   input logic [7:0] span);
    logic [7:0] d;
    d = m - base;
    return (m >= base) && (d < span);
  endfunction : in_span

  assign k_si = method - hsq_pkg::M_SINGLE_IDX_LO;
  assign k_ri = method - hsq_pkg::M_REGION_IDX_LO;
  assign k_sw = method - hsq_pkg::M_SINGLE_LO;
  assign k_rw = method - hsq_pkg::M_REGION_LO;

  // Single-switch methods are treated as a lower edge of a switch active above it.
  always_comb begin
    profile = '0;
    if (in_span(method, hsq_pkg::M_SINGLE_IDX_LO, hsq_pkg::SINGLE_SPAN)) begin
      profile.valid      = 1'b1;                         // [R1] [R2]
      profile.sig        = hsq_pkg::SIG_HOME;
      profile.start_pos  = 1'b1;
      profile.pos_active = ~k_si[1];
      profile.use_index  = 1'b1;
      profile.final_pos  = k_si[0] ^ k_si[1];
    end else if (in_span(method, hsq_pkg::M_REGION_IDX_LO, hsq_pkg::REGION_SPAN)) begin
      profile.valid      = 1'b1;                         // [R3] [R6] [R7]
      profile.sig        = hsq_pkg::SIG_HOME;
      profile.region     = 1'b1;
      profile.edge_upper = k_ri[1] ^ k_ri[2];
      profile.start_pos  = ~k_ri[2];                     // [R4] [R5]
      profile.pos_active = 1'b1;
      profile.use_index  = 1'b1;
      profile.final_pos  = k_ri[0];
    end else if (method == hsq_pkg::M_LIMIT_NEG) begin
      profile.valid      = 1'b1;                         // [R10]
      profile.sig        = hsq_pkg::SIG_NEG_LIMIT;
      profile.start_pos  = 1'b1;
      profile.final_pos  = 1'b1;
    end else if (method == hsq_pkg::M_LIMIT_POS) begin
      profile.valid      = 1'b1;                         // [R11]
      profile.sig        = hsq_pkg::SIG_POS_LIMIT;
      profile.start_pos  = 1'b1;
      profile.pos_active = 1'b1;
    end else if (in_span(method, hsq_pkg::M_SINGLE_LO, hsq_pkg::SINGLE_SPAN)) begin
      profile.valid      = 1'b1;                         // [R12] [R13] [R14] [R15]
      profile.sig        = hsq_pkg::SIG_HOME;
      profile.start_pos  = 1'b1;
      profile.pos_active = ~k_sw[1];
      profile.final_pos  = k_sw[0] ^ k_sw[1];
    end else if (in_span(method, hsq_pkg::M_REGION_LO, hsq_pkg::REGION_SPAN)) begin
      profile.valid      = 1'b1;                         // [R16] [R17]
      profile.sig        = hsq_pkg::SIG_HOME;
      profile.region     = 1'b1;
      profile.edge_upper = k_rw[1] ^ k_rw[2];
      profile.start_pos  = ~k_rw[2];                     // [R4] [R5]
      profile.pos_active = 1'b1;
      profile.final_pos  = k_rw[0];
    end else if (method == hsq_pkg::M_INDEX_NEG) begin
      profile.valid      = 1'b1;                         // [R18]
      profile.use_index  = 1'b1;
    end else if (method == hsq_pkg::M_INDEX_POS) begin
      profile.valid      = 1'b1;                         // [R19]
      profile.use_index  = 1'b1;
      profile.final_pos  = 1'b1;
    end
  end

endmodule : hsq_method_dec

// *** hw/hsq_homing_sequencer.sv ***
// Purpose: Homing sequencer that drives axis direction until the home point is found.
// Assumes: Switch and index pins are asynchronous; the motion profile lives outside.
// Notes:   Active-high switch levels; a limit in the direction of travel that is not the wanted edge ends a run, or first reverses a region search once.
//
// Functional notes
// R1 - Methods 3/4: find positive-active switch edge, then index negative or positive.
// R2 - Methods 5/6: find positive-inactive switch edge, then index positive or negative.
// R3 - Methods 7-14: region switch; find the selected edge, then the selected index.
// R4 - Methods 7-10, 23-26: start below or inside; reverse once on positive limit.
// R5 - Methods 11-14, 27-30: start above or inside; reverse once on negative limit.
// R6 - Methods 7-10 pick lower/upper edge and negative/positive index in turn.
// R7 - Methods 11-14 pick upper/lower edge and negative/positive index in turn.
// R8 - Switch-plus-index run starting inside active switch searches at slow speed.
// R9 - Methods 15, 16, 31, 32 are reserved: no motion, flagged unsupported.
// R10 - Method 17: move negative to negative limit, home where it releases moving positive.
// R11 - Method 18: move positive to positive limit, home where it releases moving negative.
// R12 - Method 19: positive-active switch, home on its falling edge moving negative.
// R13 - Method 20: positive-active switch, home on its rising edge moving positive.
// R14 - Method 21: positive-inactive switch, home where it releases moving positive.
// R15 - Method 22: positive-inactive switch, home where it activates moving negative.
// R16 - Methods 23-26: region edge without index, approached in the chosen direction.
// R17 - Methods 27-30: same, starting from the positive side.
// R18 - Method 33: move negative, home on the next index pulse.
// R19 - Method 34: move positive, home on the next index pulse.
// R20 - The method comes from a stored selection written before the run starts.
// R21 - Limit and home switches default to inputs one to three, remappable.
// R22 - Pins synchronised; at home motion stops, position loads, done flag sets.
// R23 - A limit reached without the wanted edge or index stops motion with error.
`timescale 1ns/1ps
module hsq_homing_sequencer (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // Axis pins
  input  wire logic [hsq_pkg::GEN_IN_W-1:0]  gen_in,
  input  wire logic                          index_in,
  // Configuration
  input  wire logic                          method_wr,
  input  wire logic [7:0]                    method_value,
  input  wire logic                          map_wr,
  input  wire hsq_pkg::hsq_map_t             map_value,
  input  wire logic [hsq_pkg::HOME_W-1:0]    home_offset,
  // Run control
  input  wire logic                          start,
  input  wire logic                          abort,
  // Motion command
  output hsq_pkg::hsq_motion_t               motion,
  // Position load
  output logic                               home_load,
  output logic [hsq_pkg::HOME_W-1:0]         home_value,
  // Status
  output hsq_pkg::hsq_status_t               status
);

  hsq_pkg::hsq_state_t               state_reg;
  hsq_pkg::hsq_profile_t             prof;
  hsq_pkg::hsq_map_t                 map_reg;
  logic [7:0]                        method_reg;
  logic [hsq_pkg::SYNC_W-1:0]        pin_lvl;
  logic [hsq_pkg::SYNC_W-1:0]        pin_rise;
  logic [hsq_pkg::SYNC_W-1:0]        pin_fall;
  logic [hsq_pkg::GEN_IN_W-1:0]      in_lvl;
  logic [hsq_pkg::GEN_IN_W-1:0]      in_rise;
  logic [hsq_pkg::GEN_IN_W-1:0]      in_fall;
  logic                              idx_evt;
  logic                              neg_lvl;
  logic                              pos_lvl;
  logic                              home_lvl;
  logic                              raw_lvl;
  logic                              raw_rise;
  logic                              raw_fall;
  logic                              s_lvl;
  logic                              s_rise;
  logic                              s_fall;
  logic                              edge_evt;
  logic                              lim_hit;
  logic                              active_reg;
  logic                              dir_reg;
  logic                              slow_reg;
  logic                              rev_used_reg;
  logic                              done_reg;
  logic                              error_reg;
  logic                              unsup_reg;
  logic                              load_reg;
  logic [hsq_pkg::HOME_W-1:0]        value_reg;
  logic                              in_seek;
  logic                              start_hit;
  logic                              bad_start;
  logic                              abort_hit;
  logic                              home_hit;
  logic                              to_cross;
  logic                              to_index;
  logic                              rev_hit;
  logic                              fail_hit;
  logic                              start_dir;

  function automatic logic pick(input logic [hsq_pkg::GEN_IN_W-1:0] v,
                                input logic [hsq_pkg::SEL_W-1:0]    sel);
    return v[sel];
  endfunction : pick

  // Index rides on the top bit of the synchroniser.
  hsq_sync #(
    .W (hsq_pkg::SYNC_W)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({index_in, gen_in}),                      // [R22]
    .level    (pin_lvl),
    .rise     (pin_rise),
    .fall     (pin_fall)
  );

  hsq_method_dec u_dec (
    .method  (method_reg),
    .profile (prof)
  );

  assign in_lvl  = pin_lvl[hsq_pkg::GEN_IN_W-1:0];
  assign in_rise = pin_rise[hsq_pkg::GEN_IN_W-1:0];
  assign in_fall = pin_fall[hsq_pkg::GEN_IN_W-1:0];
  assign idx_evt = pin_rise[hsq_pkg::SYNC_W-1];

  assign neg_lvl  = pick(in_lvl, map_reg.neg_sel);       // [R21]
  assign pos_lvl  = pick(in_lvl, map_reg.pos_sel);
  assign home_lvl = pick(in_lvl, map_reg.home_sel);

  // Selected switch, turned so that it always reads active on the positive side.
  always_comb begin
    case (prof.sig)
      hsq_pkg::SIG_HOME: begin
        raw_lvl  = home_lvl;
        raw_rise = pick(in_rise, map_reg.home_sel);
        raw_fall = pick(in_fall, map_reg.home_sel);
      end
      hsq_pkg::SIG_NEG_LIMIT: begin
        raw_lvl  = neg_lvl;
        raw_rise = pick(in_rise, map_reg.neg_sel);
        raw_fall = pick(in_fall, map_reg.neg_sel);
      end
      hsq_pkg::SIG_POS_LIMIT: begin
        raw_lvl  = pos_lvl;
        raw_rise = pick(in_rise, map_reg.pos_sel);
        raw_fall = pick(in_fall, map_reg.pos_sel);
      end
      default: begin
        raw_lvl  = 1'b0;
        raw_rise = 1'b0;
        raw_fall = 1'b0;
      end
    endcase
  end

  assign s_lvl  = raw_lvl ^ ~prof.pos_active;
  assign s_rise = prof.pos_active ? raw_rise : raw_fall;
  assign s_fall = prof.pos_active ? raw_fall : raw_rise;

  // Lower edge is a rise moving positive; the upper edge is the mirror case.
  assign edge_evt = (dir_reg ^ prof.edge_upper) ? s_rise : s_fall;       // [R3]
  assign lim_hit  = dir_reg ? pos_lvl : neg_lvl;

  // Inside the active zone head for the wanted edge, else assume the group's side.
  assign start_dir = (prof.sig == hsq_pkg::SIG_NONE) ? prof.final_pos :
                     (s_lvl ? prof.edge_upper : prof.start_pos);          // [R4] [R5]

  assign in_seek   = (state_reg == hsq_pkg::ST_SEEK);
  assign start_hit = (state_reg == hsq_pkg::ST_IDLE) && start && !abort;
  assign bad_start = start_hit && !prof.valid;                           // [R9]
  assign abort_hit = active_reg && abort;

  // Without an index the edge only counts when crossed in the final direction.
  assign home_hit = !abort_hit && (
                    (in_seek && edge_evt && !prof.use_index && (dir_reg == prof.final_pos))
                  || ((state_reg == hsq_pkg::ST_CROSS) && (s_rise || s_fall))
                  || ((state_reg == hsq_pkg::ST_INDEX) && idx_evt));      // [R22]
  assign to_cross = !abort_hit && in_seek && edge_evt && !prof.use_index
                    && (dir_reg != prof.final_pos);                       // [R12] [R16]
  assign to_index = !abort_hit && in_seek && edge_evt && prof.use_index;  // [R1] [R3]
  assign rev_hit  = !abort_hit && in_seek && !edge_evt && lim_hit
                    && prof.region && !rev_used_reg;                      // [R4] [R5]
  assign fail_hit = !abort_hit && !home_hit && !to_cross && !to_index && !rev_hit
                    && active_reg && lim_hit;                             // [R23]

  // Method and switch map are frozen while active_reg is high; a write in the same cycle as start still lands and changes the run.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      method_reg <= hsq_pkg::METHOD_RST;
    end else if (method_wr && !active_reg) begin
      method_reg <= method_value;                                         // [R20]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      map_reg.neg_sel  <= hsq_pkg::NEG_LIMIT_SEL_RST;                    // [R21]
      map_reg.pos_sel  <= hsq_pkg::POS_LIMIT_SEL_RST;
      map_reg.home_sel <= hsq_pkg::HOME_SEL_RST;
    end else if (map_wr && !active_reg) begin
      map_reg <= map_value;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= hsq_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        hsq_pkg::ST_IDLE: begin
          if (start_hit && prof.valid) begin
            if (prof.sig == hsq_pkg::SIG_NONE) begin
              state_reg <= hsq_pkg::ST_INDEX;                             // [R18] [R19]
            end else begin
              state_reg <= hsq_pkg::ST_SEEK;
            end
          end
        end
        hsq_pkg::ST_SEEK: begin
          if (abort_hit || home_hit || fail_hit) begin
            state_reg <= hsq_pkg::ST_IDLE;
          end else if (to_cross) begin
            state_reg <= hsq_pkg::ST_CROSS;                               // [R10] [R11]
          end else if (to_index) begin
            state_reg <= hsq_pkg::ST_INDEX;
          end
        end
        hsq_pkg::ST_CROSS, hsq_pkg::ST_INDEX: begin
          if (abort_hit || home_hit || fail_hit) begin
            state_reg <= hsq_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= hsq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_reg <= 1'b0;
    end else if (start_hit) begin
      active_reg <= prof.valid;                                           // [R9]
    end else if (abort_hit || home_hit || fail_hit) begin
      active_reg <= 1'b0;                                                 // [R22] [R23]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_reg <= 1'b0;
    end else if (start_hit) begin
      dir_reg <= start_dir;                                               // [R10] [R11]
    end else if (to_index) begin
      dir_reg <= prof.final_pos;                                          // [R6] [R7]
    end else if (to_cross || rev_hit) begin
      dir_reg <= ~dir_reg;                                                // [R13] [R14] [R15]
    end
  end

  // Edge search runs fast and the final approach slow; index-only runs, and index runs starting inside the home switch, run slow from the start.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_reg <= 1'b0;
    end else if (start_hit) begin
      slow_reg <= prof.use_index && ((prof.sig == hsq_pkg::SIG_NONE) || home_lvl); // [R8]
    end else if (to_cross || to_index) begin
      slow_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rev_used_reg <= 1'b0;
    end else if (start_hit) begin
      rev_used_reg <= 1'b0;
    end else if (rev_hit) begin
      rev_used_reg <= 1'b1;                                               // [R23]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg  <= 1'b0;
      error_reg <= 1'b0;
      unsup_reg <= 1'b0;
    end else if (start_hit) begin
      done_reg  <= 1'b0;
      error_reg <= bad_start;
      unsup_reg <= bad_start;                                             // [R9]
    end else begin
      done_reg  <= done_reg | home_hit;                                   // [R22]
      error_reg <= error_reg | fail_hit;                                  // [R23]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_reg  <= 1'b0;
      value_reg <= '0;
    end else begin
      load_reg <= home_hit;                                               // [R22]
      if (home_hit) begin
        value_reg <= home_offset;
      end
    end
  end

  assign motion.active      = active_reg;
  assign motion.dir_pos     = dir_reg;
  assign motion.slow        = slow_reg;
  assign home_load          = load_reg;
  assign home_value         = value_reg;
  assign status.busy        = active_reg;
  assign status.done        = done_reg;
  assign status.error       = error_reg;
  assign status.unsupported = unsup_reg;

endmodule : hsq_homing_sequencer

// *** bench/hsq_homing_sequencer_asserts.sv ***
// Purpose: Port-level checks for the homing sequencer.
// Assumes: One clock domain, active-low asynchronous reset.
// Notes:   Attached to the top module by the bind at the foot.
`timescale 1ns/1ps
module hsq_homing_sequencer_asserts (
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        rst_n,
  // Run control
  input wire logic                        start,
  input wire logic                        abort,
  input wire logic [hsq_pkg::HOME_W-1:0]  home_offset,
  // Outputs
  input wire hsq_pkg::hsq_motion_t        motion,
  input wire logic                        home_load,
  input wire logic [hsq_pkg::HOME_W-1:0]  home_value,
  input wire hsq_pkg::hsq_status_t        status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  busy_is_motion_a: assert property (status.busy == motion.active
    && !(status.busy && status.done)) else $error("busy differs from motion");
  start_answer_a: assert property (start && !abort && !status.busy |=>
    motion.active || (status.error && status.unsupported)) else $error("start unanswered");
  unsup_idle_a: assert property (status.unsupported |-> status.error && !motion.active)
    else $error("unsupported method moved");
  load_pulse_a: assert property (home_load |=> !home_load)
    else $error("load longer than one cycle");
  load_done_a: assert property (home_load |-> status.done && !motion.active)
    else $error("load without stop and done");
  load_value_a: assert property (home_load |-> home_value == $past(home_offset))
    else $error("home value wrong");
  fault_stop_a: assert property (status.error |-> !status.done && !home_load && !motion.active)
    else $error("error while moving or done");
  abort_stop_a: assert property (abort && status.busy |=>
    !motion.active && !status.done && !status.error) else $error("abort not clean");
  done_hold_a: assert property (status.done && !start |=> status.done)
    else $error("done dropped");
  cover property (home_load);
  cover property (status.error && !status.unsupported);
  cover property (status.unsupported);
  cover property (abort && status.busy);
endmodule : hsq_homing_sequencer_asserts

bind hsq_homing_sequencer hsq_homing_sequencer_asserts hsq_chk_inst (
  .clk(clk), .rst_n(rst_n), .start(start), .abort(abort), .home_offset(home_offset),
  .motion(motion), .home_load(home_load), .home_value(home_value), .status(status));

// *** bench/hsq_axis_model.sv ***
// Purpose: Behavioural axis with limit, home and index sensors.
// Assumes: One step per 2 cycles at search speed, per 4 at zero-search speed.
// Notes:   Spare inputs carry position bits, except bit 5, which is tied low, and bit 6, which repeats the home switch.
`timescale 1ns/1ps
module hsq_axis_model #(
  parameter int NL  = 8,
  parameter int PL  = 120,
  parameter int HLO = 50,
  parameter int HHI = 82
) (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst_n,
  // Command and setup
  input wire hsq_pkg::hsq_motion_t motion,
  input wire logic [1:0]           kind,
  input wire logic                 ld,
  input wire logic [7:0]           ld_pos,
  // Sensors
  output logic [7:0]               gen_in,
  output logic                     index_in,
  output logic [7:0]               pos
);
  logic [1:0] tick = 2'h0;
  logic       home;
  initial pos = 8'h40;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 2'h0;
    end else if (ld) begin
      pos  <= ld_pos;
      tick <= 2'h0;
    end else if (motion.active) begin
      tick <= (tick == (motion.slow ? 2'h3 : 2'h1)) ? 2'h0 : tick + 2'h1;
      if (tick == (motion.slow ? 2'h3 : 2'h1)) pos <= motion.dir_pos ? pos + 8'h01 : pos - 8'h01;
    end
  end
  // Region switch, or a single edge active on the positive or negative side.
  assign home = (kind == 2'h2) ? (pos >= HLO && pos <= HHI) : kind[0] ? (pos < HLO) : (pos >= HLO);
  assign gen_in = {pos[0], home, 1'b0, pos[1], pos[2], home, pos >= PL, pos <= NL};
  assign index_in = (pos[3:0] == 4'h0);
endmodule : hsq_axis_model

// *** bench/hsq_homing_sequencer_tb.sv ***
// Purpose: Self-checking bench for the homing sequencer.
// Assumes: Inputs change on the falling edge; the axis model closes the loop.
// Notes:   Every method 0 to 36 runs once from a random start position, then four fixed cases run.
`timescale 1ns/1ps
module hsq_homing_sequencer_tb;
  localparam int NL = 8, PL = 120, HLO = 50, HHI = 82;
  logic                 clk = 1'b0, rst_n = 1'b0, index_in, home_load, ld = 1'b0;
  logic                 method_wr = 1'b0, map_wr = 1'b0, start = 1'b0, abort = 1'b0;
  logic [7:0]           method_value = 8'h00, ld_pos = 8'h40, gen_in, pos;
  logic [1:0]           kind = 2'h0;
  logic [31:0]          home_offset = 32'h0, home_value;
  hsq_pkg::hsq_map_t    map_value = 9'h00A;
  hsq_pkg::hsq_motion_t motion;
  hsq_pkg::hsq_status_t status;
  int                   n_errors = 0, n_compared = 0, m;
  always #2.5 clk = ~clk;
  hsq_homing_sequencer hsq_homing_sequencer_inst (.clk(clk), .rst_n(rst_n), .gen_in(gen_in),
    .index_in(index_in), .method_wr(method_wr), .method_value(method_value), .map_wr(map_wr),
    .map_value(map_value), .home_offset(home_offset), .start(start), .abort(abort),
    .motion(motion), .home_load(home_load), .home_value(home_value), .status(status));
  hsq_axis_model #(.NL(NL), .PL(PL), .HLO(HLO), .HHI(HHI)) hsq_axis_model_inst (.clk(clk),
    .rst_n(rst_n), .motion(motion), .kind(kind), .ld(ld), .ld_pos(ld_pos), .gen_in(gen_in),
    .index_in(index_in), .pos(pos));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic exp_dir(int m, logic s);
    if (m == 33 || m == 17) return 1'b0;
    if (m == 34) return 1'b1;
    if (s) return m inside {[9:12], [25:28]};
    return !(m inside {[11:14], [27:30]});
  endfunction : exp_dir
  function automatic int exp_edge(int m);
    if (m == 17) return NL;
    if (m == 18) return PL;
    return (m inside {[9:12], [25:28]}) ? HHI + 1 : HLO;
  endfunction : exp_edge
  task automatic run(input int m, input int p, input logic [2:0] hsel, input bit ab);
    logic ok, idx, hs, s;
    int   i, d;
    ok  = m inside {[3:14], [17:30], 33, 34};
    idx = m inside {[3:14], 33, 34};
    @(negedge clk);
    method_wr    = 1'b1;
    method_value = m[7:0];
    map_wr       = 1'b1;
    map_value    = {3'h0, 3'h1, hsel};
    ld           = 1'b1;
    ld_pos       = p[7:0];
    home_offset  = $urandom;
    kind = (m inside {5, 6, 21, 22}) ? 2'h1 : ((m inside {[7:14], [23:30]}) ? 2'h2 : 2'h0);
    @(negedge clk);
    method_wr = 1'b0;
    map_wr    = 1'b0;
    ld        = 1'b0;
    repeat (4) @(negedge clk);
    hs = gen_in[hsel];
    s  = (m == 17) ? !gen_in[0] : (m == 18) ? gen_in[1] : (kind == 2'h1) ? !hs : hs;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    chk(motion.active, ok);
    chk({status.unsupported, status.error}, {!ok, !ok});
    if (ok) begin
      chk(motion.dir_pos, exp_dir(m, s));
      chk(motion.slow, m inside {33, 34} || (m inside {[3:14]} && hs));
    end
    if (ab) begin
      @(negedge clk) abort = 1'b1;
      @(negedge clk) abort = 1'b0;
      chk({motion.active, status.done, status.error}, 3'h0);
    end else if (ok) begin
      for (i = 0; i < 6000 && status.busy === 1'b1; i++) @(negedge clk);
      chk({status.done, status.error}, (hsel == 3'h5) ? 2'h1 : 2'h2);
      if (status.done === 1'b1) begin
        chk(home_value, home_offset);
        d = int'(pos) - exp_edge(m);
        if (idx) chk(pos[3:0], 4'h0);
        else chk(d <= 2 && d >= -2, 1'b1);
      end
    end
  endtask : run
  task automatic conclude();
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    #400000;
    n_errors++;
    conclude();
  end
  initial begin
    void'($urandom(32'h3E33));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    // Starts stay strictly inside the outer index marks, so index-only runs always find one.
    for (m = 0; m <= 36; m++) run(m, 17 + $urandom_range(94), 3'h2, 1'b0);
    run(8, 100, 3'h2, 1'b0);
    run(27, 30, 3'h6, 1'b0);
    run(10, 100, 3'h5, 1'b0);
    run(34, 60, 3'h2, 1'b1);
    conclude();
  end
endmodule : hsq_homing_sequencer_tb
